// file: pkg/snp_pkg.sv
// Shared constants and types for the serial NAND page cache block
package snp_pkg;

  // Page geometry
  localparam int unsigned SNP_DATA_BYTES = 2048;  // Main data area of a page
  localparam int unsigned SNP_SPARE_ECC_ON = 64;  // Spare visible with correction on
  localparam int unsigned SNP_SPARE_ECC_OFF = 128;  // Spare visible with correction off
  localparam int unsigned SNP_PAGE_BYTES = SNP_DATA_BYTES + SNP_SPARE_ECC_OFF;
  localparam int unsigned SNP_CW_BYTES = 528;  // Bytes covered by one parity group
  localparam int unsigned SNP_CW_COUNT = 4;  // Parity groups per page
  localparam logic [11:0] SNP_SPARE_COL = 12'h800;  // First spare byte
  localparam logic [11:0] SNP_PARITY_COL = 12'h840;  // First parity byte, after user spare
  localparam logic [11:0] SNP_PARITY_END = 12'h844;  // One past the last parity byte

  // Link commands
  localparam logic [7:0] CMD_WR_EN = 8'h06;
  localparam logic [7:0] CMD_WR_DIS = 8'h04;
  localparam logic [7:0] CMD_GET_FEAT = 8'h0F;
  localparam logic [7:0] CMD_SET_FEAT = 8'h1F;
  localparam logic [7:0] CMD_PAGE_READ = 8'h13;
  localparam logic [7:0] CMD_READ_CACHE = 8'h03;
  localparam logic [7:0] CMD_READ_FAST = 8'h0B;
  localparam logic [7:0] CMD_READ_X4 = 8'h6B;
  localparam logic [7:0] CMD_PROG_LOAD = 8'h02;
  localparam logic [7:0] CMD_PROG_LOAD_X4 = 8'h32;
  localparam logic [7:0] CMD_PROG_EXEC = 8'h10;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'hD8;

  // Feature addresses and bit positions
  localparam logic [7:0] FEAT_CFG = 8'hB0;
  localparam logic [7:0] FEAT_STATUS = 8'hC0;
  localparam int unsigned CFG_QUAD_BIT = 0;
  localparam int unsigned CFG_ECC_BIT = 4;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_WEL_BIT = 1;
  localparam int unsigned STAT_ECC_LSB = 4;

  // Correction results and values after reset
  localparam logic [1:0] ECC_CLEAN = 2'h0;
  localparam logic [1:0] ECC_UNCORR = 2'h2;
  localparam logic RST_ECC_EN = 1'b1;
  localparam logic RST_QUAD = 1'b0;
  localparam logic [5:0] RST_PINS = 6'h30;  // Chip select and clock idle high

  // Counts of cycles in the array engine
  localparam logic [12:0] LOAD_LATENCY = 13'h0002;  // Request to captured byte

  // Link phase, one-hot
  typedef enum logic [5:0] {
    PH_CMD = 6'h01,
    PH_ADDR = 6'h02,
    PH_DUMMY = 6'h04,
    PH_DIN = 6'h08,
    PH_DOUT = 6'h10,
    PH_SKIP = 6'h20
  } snp_phase_t;

  // Array engine state, one-hot
  typedef enum logic [4:0] {
    E_IDLE = 5'h01,
    E_LOAD = 5'h02,
    E_CHECK = 5'h04,
    E_PROG = 5'h08,
    E_ERASE = 5'h10
  } snp_eng_t;

endpackage

// file: verilog/snp_fifo.sv
// Small buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module snp_fifo import snp_pkg::*; #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_flush,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // Entry storage
    logic [PW-1:0] wp;  // Write index
    logic [PW-1:0] rp;  // Read index
    logic [CW-1:0] cnt;  // Entries held
  } snp_fifo_state_t;

  snp_fifo_state_t st;
  snp_fifo_state_t next_st;
  logic push;
  logic pop;

  // Wrap an index at the depth
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // Full and empty come straight from the count, so neither can lie
  assign o_ready = (st.cnt != CW'(DEPTH));
  assign o_valid = (st.cnt != '0);
  assign o_data = st.mem[st.rp];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  // Next state
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = i_data;
      next_st.wp = bump(st.wp);
    end
    if (pop) begin
      next_st.rp = bump(st.rp);
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + CW'(1);
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - CW'(1);
    end
    // Flush drops stale bytes when a frame ends
    if (i_flush) begin
      next_st.wp = '0;
      next_st.rp = '0;
      next_st.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // snp_fifo
`default_nettype wire

// file: verilog/snp_core.sv
// Serial NAND device: link slave, cache and data registers, array engine
`timescale 1ns/1ns
`default_nettype none
module snp_core import snp_pkg::*; #(
  parameter int unsigned PAGE_BYTES = SNP_PAGE_BYTES,
  parameter bit HAS_STROBE = 1'b1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Serial link pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_serial_lane,
  output logic [3:0] o_serial_lane,
  output logic [3:0] o_serial_lane_oe,
  output logic o_strobe,
  output logic o_strobe_oe,
  // Array port, one byte per request
  output logic o_arr_en,
  output logic o_arr_we,
  output logic o_arr_erase,
  output logic [17:0] o_arr_row,
  output logic [11:0] o_arr_col,
  output logic [7:0] o_arr_wdata,
  input wire logic [7:0] i_arr_rdata,
  // Device state
  output logic o_busy
);

  localparam logic [11:0] PAGE_LIM = 12'(PAGE_BYTES);
  localparam logic [12:0] PAGE13 = 13'(PAGE_BYTES);

  typedef struct packed {
    logic [5:0] meta;  // First sync stage: cs_n, sclk, lanes
    logic [5:0] syn;  // Second sync stage
    logic sclk_q;  // Previous synced clock, for edges
    snp_phase_t ph;  // Link phase
    logic [7:0] cmd;  // Current command
    logic [7:0] sh_in;  // Input shifter
    logic [3:0] bit_cnt;  // Bits collected in this byte
    logic [1:0] acnt;  // Address bytes taken
    logic [23:0] addr;  // Address accumulator
    logic [7:0] feat_addr;  // Feature being read or written
    logic [11:0] col;  // Cache column pointer
    logic [7:0] osh;  // Output shifter
    logic [3:0] oleft;  // Bits still to send from osh
    logic [3:0] lane_o;  // Lane output levels
    logic [3:0] lane_oe;  // Lane drive enables
    logic strobe;  // Read strobe level
    logic strobe_oe;  // Read strobe enable
    logic qe;  // quad_lane_enable
    logic ecc_en;  // Internal correction enable
    logic wel;  // Write enable latch
    logic [1:0] ecc_stat;  // Result of last page load
    logic pend;  // Power-up load still owed
    snp_eng_t eng;  // Array engine state
    logic [17:0] row;  // Page or block row
    logic [12:0] ecnt;  // Engine byte counter
    logic [SNP_CW_COUNT-1:0][7:0] par;  // Running parity per group
    logic arr_en;
    logic arr_we;
    logic arr_erase;
    logic [11:0] arr_col;
    logic [7:0] arr_wdata;
    logic [PAGE_BYTES-1:0][7:0] cache;  // Cache register
    logic [PAGE_BYTES-1:0][7:0] dreg;  // Data register
  } snp_core_state_t;

  snp_core_state_t st;
  snp_core_state_t next_st;
  logic rise;  // Synced clock rising edge
  logic fall;  // Synced clock falling edge
  logic busy;
  logic hold_act;  // Pause pin active
  logic in_quad;
  logic out_quad;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [7:0] fifo_out_data;

  // Last address byte index per command
  function automatic logic [1:0] addr_last(input logic [7:0] c);
    if (c == CMD_GET_FEAT || c == CMD_SET_FEAT) begin
      return 2'h0;
    end else if (c == CMD_PAGE_READ || c == CMD_PROG_EXEC || c == CMD_BLOCK_ERASE) begin
      return 2'h2;
    end else begin
      return 2'h1;
    end
  endfunction

  // Parity group of a column: {valid, index}; data and user spare only
  function automatic logic [2:0] cw_of(input logic [11:0] c);
    if (c < SNP_SPARE_COL) begin
      return {1'b1, c[10:9]};
    end else if (c < SNP_PARITY_COL) begin
      return {1'b1, c[5:4]};
    end else begin
      return 3'h0;
    end
  endfunction

  // Feature byte seen by the host
  function automatic logic [7:0] feat_read(input snp_core_state_t s, input logic bsy);
    logic [7:0] v;
    v = 8'h00;
    if (s.feat_addr == FEAT_CFG) begin
      v[CFG_QUAD_BIT] = s.qe;
      v[CFG_ECC_BIT] = s.ecc_en;
    end else if (s.feat_addr == FEAT_STATUS) begin
      v[STAT_BUSY_BIT] = bsy;
      v[STAT_WEL_BIT] = s.wel;
      v[STAT_ECC_LSB +: 2] = s.ecc_stat;
    end
    return v;
  endfunction

  assign rise = st.syn[4] & ~st.sclk_q;
  assign fall = ~st.syn[4] & st.sclk_q;
  // The last array pulse leaves after the engine idles, so it still counts as busy
  assign busy = (st.eng != E_IDLE) | st.pend | st.arr_en | st.arr_erase;
  // Unused pause pin must sit high, or the link would freeze here
  assign hold_act = ~st.qe & ~st.syn[3];
  assign in_quad = (st.ph == PH_DIN) & (st.cmd == CMD_PROG_LOAD_X4);
  assign out_quad = (st.cmd == CMD_READ_X4);
  assign fifo_in_valid = (st.ph == PH_DOUT) & ~st.syn[5];
  assign fifo_in_data = (st.cmd == CMD_GET_FEAT) ? feat_read(st, busy) :
                        (st.col < PAGE_LIM) ? st.cache[st.col] : 8'hFF;
  assign o_serial_lane = st.lane_o;
  assign o_serial_lane_oe = st.lane_oe;
  assign o_strobe = st.strobe;
  assign o_strobe_oe = st.strobe_oe;
  assign o_arr_en = st.arr_en;
  assign o_arr_we = st.arr_we;
  assign o_arr_erase = st.arr_erase;
  assign o_arr_row = st.row;
  assign o_arr_col = st.arr_col;
  assign o_arr_wdata = st.arr_wdata;
  assign o_busy = busy;

  // Two entries decouple the cache fetch from the shift-out pace
  snp_fifo #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_flush(st.syn[5]),
    .i_valid(fifo_in_valid),
    .o_ready(fifo_in_ready),
    .i_data(fifo_in_data),
    .o_valid(fifo_out_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_out_data)
  );

  // Next state: synchroniser, array engine, then link decoding
  always_comb begin
    logic [7:0] b;
    logic [3:0] cnt;
    logic [11:0] idx;
    logic [2:0] cw;
    b = 8'h00;
    cnt = 4'h0;
    idx = 12'h000;
    cw = 3'h0;
    next_st = st;
    fifo_pop = 1'b0;
    next_st.meta = {i_cs_n, i_sclk, i_serial_lane};
    next_st.syn = st.meta;
    next_st.sclk_q = st.syn[4];
    next_st.arr_en = 1'b0;
    next_st.arr_we = 1'b0;
    next_st.arr_erase = 1'b0;

    // Array engine works on whole pages and blocks only
    case (st.eng)
      E_IDLE: begin
        if (st.pend) begin
          next_st.eng = E_LOAD;
          next_st.row = 18'h00000;
          next_st.ecnt = 13'h0000;
          next_st.par = '0;
          next_st.pend = 1'b0;
        end
      end
      E_LOAD: begin
        if (st.ecnt < PAGE13) begin
          next_st.arr_en = 1'b1;
          next_st.arr_col = st.ecnt[11:0];
        end
        // Read data trails the request by the port latency
        if (st.ecnt >= LOAD_LATENCY) begin
          idx = 12'(st.ecnt - LOAD_LATENCY);
          next_st.dreg[idx] = i_arr_rdata;
          cw = cw_of(idx);
          if (cw[2]) begin
            next_st.par[cw[1:0]] = st.par[cw[1:0]] ^ i_arr_rdata;
          end
        end
        next_st.ecnt = st.ecnt + 13'h0001;
        if (st.ecnt == PAGE13 + 13'h0001) begin
          next_st.eng = E_CHECK;
        end
      end
      E_CHECK: begin
        next_st.ecc_stat = ECC_CLEAN;
        if (st.ecc_en) begin
          for (int i = 0; i < SNP_CW_COUNT; i++) begin
            if (~st.par[i] != st.dreg[SNP_PARITY_COL + 12'(i)]) begin
              next_st.ecc_stat = ECC_UNCORR;
            end
          end
        end
        next_st.cache = st.dreg;
        next_st.eng = E_IDLE;
      end
      E_PROG: begin
        idx = st.ecnt[11:0];
        next_st.arr_en = 1'b1;
        next_st.arr_we = 1'b1;
        next_st.arr_col = idx;
        next_st.arr_wdata = st.dreg[idx];
        // Parity is stored inverted so an erased page checks clean
        if (st.ecc_en && idx >= SNP_PARITY_COL && idx < SNP_PARITY_END) begin
          next_st.arr_wdata = ~st.par[idx[1:0]];
        end else if (st.ecc_en && idx >= SNP_PARITY_END) begin
          next_st.arr_wdata = 8'hFF;
        end
        cw = cw_of(idx);
        if (cw[2]) begin
          next_st.par[cw[1:0]] = st.par[cw[1:0]] ^ st.dreg[idx];
        end
        next_st.ecnt = st.ecnt + 13'h0001;
        if (st.ecnt == PAGE13 - 13'h0001) begin
          next_st.eng = E_IDLE;
        end
      end
      E_ERASE: begin
        next_st.arr_erase = 1'b1;
        next_st.eng = E_IDLE;
      end
      default: begin
        next_st.eng = E_IDLE;
      end
    endcase

    // Chip select high ends any frame and idles the lanes
    if (st.syn[5]) begin
      next_st.ph = PH_CMD;
      next_st.bit_cnt = 4'h0;
      next_st.acnt = 2'h0;
      next_st.oleft = 4'h0;
      next_st.strobe_oe = 1'b0;
      next_st.strobe = 1'b0;
    end else if (!hold_act) begin
      // Inputs are taken on the rising edge
      if (rise && st.ph != PH_DOUT && st.ph != PH_SKIP) begin
        b = in_quad ? {st.sh_in[3:0], st.syn[3:0]} : {st.sh_in[6:0], st.syn[0]};
        cnt = st.bit_cnt + (in_quad ? 4'h4 : 4'h1);
        next_st.sh_in = b;
        next_st.bit_cnt = (cnt == 4'h8) ? 4'h0 : cnt;
        if (cnt == 4'h8) begin
          case (st.ph)
            PH_CMD: begin
              next_st.cmd = b;
              next_st.acnt = 2'h0;
              case (b)
                CMD_WR_EN: begin
                  next_st.wel = 1'b1;
                  next_st.ph = PH_SKIP;
                end
                CMD_WR_DIS: begin
                  next_st.wel = 1'b0;
                  next_st.ph = PH_SKIP;
                end
                CMD_GET_FEAT, CMD_SET_FEAT, CMD_PAGE_READ, CMD_PROG_EXEC, CMD_BLOCK_ERASE,
                CMD_READ_CACHE, CMD_READ_FAST, CMD_PROG_LOAD: begin
                  next_st.ph = PH_ADDR;
                end
                CMD_READ_X4, CMD_PROG_LOAD_X4: begin
                  next_st.ph = st.qe ? PH_ADDR : PH_SKIP;
                end
                default: begin
                  next_st.ph = PH_SKIP;
                end
              endcase
            end
            PH_ADDR: begin
              next_st.addr = {st.addr[15:0], b};
              next_st.acnt = st.acnt + 2'h1;
              if (st.acnt == addr_last(st.cmd)) begin
                if (st.cmd == CMD_GET_FEAT) begin
                  next_st.feat_addr = b;
                  next_st.ph = PH_DOUT;
                end else if (st.cmd == CMD_SET_FEAT) begin
                  next_st.feat_addr = b;
                  next_st.ph = PH_DIN;
                end else if (st.cmd == CMD_PAGE_READ) begin
                  if (!busy) begin
                    next_st.eng = E_LOAD;
                    next_st.row = {st.addr[9:0], b};
                    next_st.ecnt = 13'h0000;
                    next_st.par = '0;
                  end
                  next_st.ph = PH_SKIP;
                end else if (st.cmd == CMD_PROG_EXEC || st.cmd == CMD_BLOCK_ERASE) begin
                  if (!busy && st.wel) begin
                    next_st.eng = (st.cmd == CMD_PROG_EXEC) ? E_PROG : E_ERASE;
                    next_st.row = {st.addr[9:0], b};
                    next_st.ecnt = 13'h0000;
                    next_st.par = '0;
                    next_st.dreg = st.cache;
                    next_st.wel = 1'b0;
                  end
                  next_st.ph = PH_SKIP;
                end else begin
                  next_st.col = {st.addr[3:0], b};
                  next_st.ph = (st.cmd == CMD_PROG_LOAD || st.cmd == CMD_PROG_LOAD_X4) ?
                               PH_DIN : PH_DUMMY;
                end
              end
            end
            PH_DUMMY: begin
              next_st.ph = PH_DOUT;
              next_st.strobe_oe = HAS_STROBE & out_quad;
              next_st.strobe = 1'b0;
            end
            PH_DIN: begin
              if (st.cmd == CMD_SET_FEAT) begin
                if (st.feat_addr == FEAT_CFG) begin
                  next_st.qe = b[CFG_QUAD_BIT];
                  next_st.ecc_en = b[CFG_ECC_BIT];
                end
              end else if (!busy && st.col < PAGE_LIM) begin
                next_st.cache[st.col] = b;
                next_st.col = st.col + 12'h001;
              end
            end
            default: begin
              next_st.ph = st.ph;
            end
          endcase
        end
      end
      // Outputs move on the falling edge
      if (fall && st.ph == PH_DOUT) begin
        if (st.oleft == 4'h0) begin
          if (fifo_out_valid) begin
            fifo_pop = 1'b1;
            next_st.lane_o = out_quad ? fifo_out_data[7:4] : {2'h0, fifo_out_data[7], 1'b0};
            next_st.osh = out_quad ? {fifo_out_data[3:0], 4'h0} : {fifo_out_data[6:0], 1'b0};
            next_st.oleft = out_quad ? 4'h4 : 4'h7;
          end
        end else begin
          next_st.lane_o = out_quad ? st.osh[7:4] : {2'h0, st.osh[7], 1'b0};
          next_st.osh = out_quad ? {st.osh[3:0], 4'h0} : {st.osh[6:0], 1'b0};
          next_st.oleft = st.oleft - (out_quad ? 4'h4 : 4'h1);
        end
        if (st.strobe_oe) begin
          next_st.strobe = ~st.strobe;
        end
      end
    end

    // Lane drive only in a live, unpaused output phase
    next_st.lane_oe = 4'h0;
    if (!st.syn[5] && !hold_act && st.ph == PH_DOUT) begin
      next_st.lane_oe = out_quad ? 4'hF : 4'h2;
    end

    // Cache pointer advances as bytes enter the buffer
    if (fifo_in_valid && fifo_in_ready && st.cmd != CMD_GET_FEAT && st.col < PAGE_LIM) begin
      next_st.col = st.col + 12'h001;
    end
  end

  // State register; chip select and clock idle high, lanes low, until sampled
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.meta <= RST_PINS;
      st.syn <= RST_PINS;
      st.sclk_q <= 1'b1;
      st.ph <= PH_CMD;
      st.eng <= E_IDLE;
      st.pend <= 1'b1;
      st.ecc_en <= RST_ECC_EN;
      st.qe <= RST_QUAD;
    end else begin
      st <= next_st;
    end
  end

endmodule // snp_core
`default_nettype wire

// file: bench/snp_core_assertions.sv
// Port checker for the serial NAND page cache core
`timescale 1ns/1ns
`default_nettype none
module snp_core_chk import snp_pkg::*; #(
  parameter int unsigned PAGE_BYTES = SNP_PAGE_BYTES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Link side
  input wire logic i_cs_n,
  input wire logic [3:0] o_serial_lane_oe,
  input wire logic o_strobe_oe,
  // Array side
  input wire logic o_arr_en,
  input wire logic o_arr_we,
  input wire logic o_arr_erase,
  input wire logic [17:0] o_arr_row,
  input wire logic [11:0] o_arr_col,
  input wire logic o_busy
);
  // One clock domain, so one default clock and reset
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // Every page access starts at column zero and climbs by one
  AST_COL0: assert property ($rose(o_arr_en) |-> o_arr_col == 12'h000)
    else $error("page access did not start at column zero");
  AST_COL_STEP: assert property (o_arr_en && $past(o_arr_en) |->
    o_arr_col == $past(o_arr_col) + 12'h001) else $error("column did not step by one");
  AST_ROW_HOLD: assert property (o_arr_en && $past(o_arr_en) |-> $stable(o_arr_row))
    else $error("row moved inside a page access");
  // Whole page of data plus full spare area, nothing shorter
  AST_PAGE_END: assert property ($fell(o_arr_en) |->
    $past(o_arr_col) == 12'(PAGE_BYTES - 1)) else $error("page access ended early");
  AST_ERASE_ONE: assert property (o_arr_erase |=> !o_arr_erase && !o_arr_en)
    else $error("erase not a single pulse");
  // Array activity must show as busy in status
  AST_BUSY_ARR: assert property (o_arr_en || o_arr_erase |-> o_busy)
    else $error("array active while not busy");
  // Deselected link must release every lane
  AST_CS_IDLE: assert property (i_cs_n [*6] |-> o_serial_lane_oe == 4'h0)
    else $error("lane driven while deselected");
  AST_LANES: assert property (o_serial_lane_oe != 4'h0 |->
    o_serial_lane_oe inside {4'h2, 4'hF}) else $error("illegal lane drive set");
  AST_STB_QUAD: assert property ($rose(o_strobe_oe) |-> ##[0:4] o_serial_lane_oe == 4'hF)
    else $error("strobe without quad lanes");

  // Main scenarios reached
  COV_ERASE: cover property (o_arr_erase);
  COV_PROG: cover property (o_arr_en && o_arr_we);
  COV_STROBE: cover property (o_strobe_oe);
endmodule // snp_core_chk

bind snp_core snp_core_chk #(.PAGE_BYTES(PAGE_BYTES)) u_chk (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_cs_n(i_cs_n), .o_serial_lane_oe(o_serial_lane_oe),
  .o_strobe_oe(o_strobe_oe), .o_arr_en(o_arr_en), .o_arr_we(o_arr_we),
  .o_arr_erase(o_arr_erase), .o_arr_row(o_arr_row), .o_arr_col(o_arr_col), .o_busy(o_busy));
`default_nettype wire

// file: bench/snp_host.sv
// Host controller model that drives the serial link in mode 0
`timescale 1ns/1ns
`default_nettype none
module snp_host import snp_pkg::*; (
  // Lane levels seen on the wires
  input wire logic [3:0] i_lane,
  // Link outputs
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_drv
);
  // Idle: clock still and low, deselected, protect and pause high
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_drv = 4'hF;
  end

  // Open a frame
  task automatic start();
    o_cs_n = 1'b0;
    #63;
  endtask

  // Close a frame; lane 0 flips so stale data is never reused
  task automatic stop();
    #63;
    o_cs_n = 1'b1;
    o_drv[0] = ~o_drv[0];
    o_drv[3:1] = 3'h7;
    #100;
  endtask

  // One byte, MSB first: eight single clocks or two quad clocks
  task automatic xb(input logic [7:0] tx, input logic q, output logic [7:0] rx);
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      if (q) o_drv = tx[7 - 4*i -: 4];
      else o_drv[0] = tx[7 - i];
      #62;
      o_sclk = 1'b1;
      rx = q ? {rx[3:0], i_lane} : {rx[6:0], i_lane[1]};
      #63;
      o_sclk = 1'b0;
    end
  endtask
endmodule // snp_host
`default_nettype wire

// file: bench/test_serial_nand_page_cache_ecc.sv
// Self-checking bench for the serial NAND page cache core
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %0h exp %0h", $time, g, e); end end
module test_serial_nand_page_cache_ecc import snp_pkg::*;;
  logic i_ref_clk = 1'b0; // 100 MHz
  logic i_rst = 1'b1; // Held two cycles
  logic sclk, cs_n, stb, stb_oe, arr_en, arr_we, arr_er, busy;
  logic [3:0] hdrv, lane_w, lane_out, lane_oe;
  logic [17:0] row;
  logic [11:0] col;
  logic [7:0] wdata, v;
  logic [7:0] rdata = 8'h00;
  logic [7:0] mem [logic [29:0]]; // Absent entries read as erased
  logic [3:0] oe_or = 4'h0; // Lanes ever driven in a frame
  logic stb_or = 1'b0;
  int n_mismatch = 0, checks_done = 0, n_rd = 0, n_wr = 0, n_er = 0, cyc = 0;

  always #5 i_ref_clk = ~i_ref_clk;
  // Wire level: device drive wins where enabled
  assign lane_w = (lane_oe & lane_out) | (~lane_oe & hdrv);

  snp_host u_host (.i_lane(lane_w), .o_sclk(sclk), .o_cs_n(cs_n), .o_drv(hdrv));
  snp_core uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_serial_lane(lane_w), .o_serial_lane(lane_out), .o_serial_lane_oe(lane_oe),
    .o_strobe(stb), .o_strobe_oe(stb_oe), .o_arr_en(arr_en), .o_arr_we(arr_we),
    .o_arr_erase(arr_er), .o_arr_row(row), .o_arr_col(col), .o_arr_wdata(wdata),
    .i_arr_rdata(rdata), .o_busy(busy));

  // Array model; between reads the data toggles so nothing stale passes
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    oe_or <= oe_or | lane_oe;
    stb_or <= stb_or | (stb_oe & stb); // Strobe enabled and seen high
    rdata <= ~rdata;
    if (arr_en && arr_we) begin
      mem[{row, col}] = wdata;
      n_wr++;
    end
    if (arr_en && !arr_we) begin
      rdata <= mem.exists({row, col}) ? mem[{row, col}] : 8'hFF;
      n_rd++;
    end
    if (arr_er) n_er++;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report();
    end
  end

  // Frame opening: command then na address bytes, high first
  task automatic cmd(input logic [7:0] c, input int na, input logic [23:0] a);
    u_host.start();
    u_host.xb(c, 1'b0, v);
    for (int i = na; i > 0; i--) u_host.xb(a[8*i-1 -: 8], 1'b0, v);
  endtask

  // Feature read; last of four bytes clears any prefetch lag
  task automatic get_feat(input logic [7:0] a);
    cmd(CMD_GET_FEAT, 1, {16'h0000, a});
    repeat (4) u_host.xb(8'h00, 1'b0, v);
    u_host.stop();
  endtask

  // Bounded wait for the array engine
  task automatic wait_idle();
    repeat (10) @(posedge i_ref_clk);
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge i_ref_clk);
    `CHK(busy, 1'b0)
  endtask

  task automatic t_powerup();
    `CHK(busy, 1'b1)
    wait_idle();
    `CHK(n_rd, 2176)
    get_feat(FEAT_CFG);
    `CHK(v & 8'h11, 8'h10)
    $display("powerup done");
  endtask

  // Quad read refused without quad enable, then quad load and read on four lanes
  task automatic t_quad();
    oe_or = 4'h0;
    cmd(CMD_READ_X4, 2, 24'h0);
    u_host.xb(8'h00, 1'b0, v);
    u_host.xb(8'hFF, 1'b1, v);
    u_host.stop();
    `CHK(oe_or, 4'h0)
    cmd(CMD_SET_FEAT, 1, {16'h0000, FEAT_CFG});
    u_host.xb(8'h11, 1'b0, v);
    u_host.stop();
    cmd(CMD_PROG_LOAD_X4, 2, 24'h000801);
    u_host.xb(8'hC3, 1'b1, v);
    u_host.stop();
    oe_or = 4'h0;
    stb_or = 1'b0;
    cmd(CMD_READ_X4, 2, 24'h000801);
    u_host.xb(8'h00, 1'b0, v);
    u_host.xb(8'hFF, 1'b1, v);
    u_host.stop();
    `CHK(v, 8'hC3)
    `CHK(oe_or, 4'hF)
    `CHK(stb_or, 1'b1)
    cmd(CMD_SET_FEAT, 1, {16'h0000, FEAT_CFG});
    u_host.xb(8'h10, 1'b0, v);
    u_host.stop();
    $display("quad done");
  endtask

  // Spare byte loaded, then cache moved from page 0 to page 7 of the same block
  task automatic t_program();
    cmd(CMD_PROG_LOAD, 2, 24'h000800);
    u_host.xb(8'h5A, 1'b0, v);
    u_host.stop();
    cmd(CMD_WR_EN, 0, 24'h0);
    u_host.stop();
    cmd(CMD_PROG_EXEC, 3, 24'h000007);
    u_host.stop();
    get_feat(FEAT_STATUS);
    `CHK(v[1:0], 2'b01)
    wait_idle();
    `CHK(n_wr, 2176)
    `CHK(mem[{18'h00007, 12'h800}], 8'h5A)
    // Group 0 parity: inverted XOR of 5A and C3, all other bytes erased
    `CHK(mem[{18'h00007, 12'h840}], 8'h66)
    $display("program done");
  endtask

  // Clean page, then one flipped byte flagged and still delivered
  task automatic t_ecc();
    cmd(CMD_PAGE_READ, 3, 24'h000005);
    u_host.stop();
    wait_idle();
    get_feat(FEAT_STATUS);
    `CHK(v[5:4], ECC_CLEAN)
    mem[{18'h00005, 12'h005}] = 8'h00;
    cmd(CMD_PAGE_READ, 3, 24'h000005);
    u_host.stop();
    wait_idle();
    get_feat(FEAT_STATUS);
    `CHK(v[5:4], ECC_UNCORR)
    cmd(CMD_READ_CACHE, 2, 24'h000005);
    u_host.xb(8'h00, 1'b0, v);
    u_host.xb(8'h00, 1'b0, v);
    u_host.stop();
    `CHK(v, 8'h00)
    // Correction off: same damaged page now loads with a clean result
    cmd(CMD_SET_FEAT, 1, {16'h0000, FEAT_CFG});
    u_host.xb(8'h00, 1'b0, v);
    u_host.stop();
    cmd(CMD_PAGE_READ, 3, 24'h000005);
    u_host.stop();
    wait_idle();
    get_feat(FEAT_STATUS);
    `CHK(v[5:4], ECC_CLEAN)
    cmd(CMD_READ_FAST, 2, 24'h000005);
    u_host.xb(8'h00, 1'b0, v);
    u_host.xb(8'h00, 1'b0, v);
    u_host.stop();
    `CHK(v, 8'h00)
    $display("ecc done");
  endtask

  // Abandoned frame, erase, then erase without write enable
  task automatic t_erase();
    cmd(CMD_GET_FEAT, 0, 24'h0);
    u_host.stop();
    cmd(CMD_WR_EN, 0, 24'h0);
    u_host.stop();
    cmd(CMD_BLOCK_ERASE, 3, 24'h000040);
    u_host.stop();
    wait_idle();
    `CHK(n_er, 1)
    cmd(CMD_WR_EN, 0, 24'h0);
    u_host.stop();
    cmd(CMD_WR_DIS, 0, 24'h0);
    u_host.stop();
    cmd(CMD_BLOCK_ERASE, 3, 24'h000040);
    u_host.stop();
    wait_idle();
    `CHK(n_er, 1)
    $display("erase done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    t_powerup();
    t_quad();
    t_program();
    t_ecc();
    t_erase();
    final_report();
  end
endmodule // test_serial_nand_page_cache_ecc
`default_nettype wire
